//--- rtl/bwv_pkg.sv
package bwv_pkg;

  // Size of the tracked block map.
  localparam int unsigned NBLK = 64;
  localparam int unsigned IDXW = 6;

  // Opcodes of the handled commands.
  localparam logic [7:0] OPC_WR = 8'h01;
  localparam logic [7:0] OPC_RD = 8'h02;
  localparam logic [7:0] OPC_WU = 8'h04;
  localparam logic [7:0] OPC_WZ = 8'h08;

  // Status code types and codes.
  localparam logic [2:0] SCT_GEN     = 3'h0;
  localparam logic [2:0] SCT_CS      = 3'h1;
  localparam logic [2:0] SCT_MEDIA   = 3'h2;
  localparam logic [7:0] SC_OK       = 8'h00;
  localparam logic [7:0] SC_BAD_OPC  = 8'h01;
  localparam logic [7:0] SC_RANGE    = 8'h80;
  localparam logic [7:0] SC_CONFLICT = 8'h80;
  localparam logic [7:0] SC_BAD_PI   = 8'h81;
  localparam logic [7:0] SC_RO       = 8'h82;
  localparam logic [7:0] SC_URE      = 8'h81;

  // Register byte offsets.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_DW10   = 8'h08;
  localparam logic [7:0] A_DW11   = 8'h0c;
  localparam logic [7:0] A_DW12   = 8'h10;
  localparam logic [7:0] A_DW13   = 8'h14;
  localparam logic [7:0] A_DW14   = 8'h18;
  localparam logic [7:0] A_DW15   = 8'h1c;
  localparam logic [7:0] A_ROFST  = 8'h20;
  localparam logic [7:0] A_ROLST  = 8'h24;
  localparam logic [7:0] A_CPL    = 8'h28;
  localparam logic [7:0] A_CPLCID = 8'h2c;

  // Field positions.
  localparam int unsigned CTRL_GO   = 0;
  localparam int unsigned CTRL_PIF  = 1;
  localparam int unsigned CTRL_ROEN = 2;
  localparam int unsigned CMD_CID   = 16;
  localparam int unsigned CPL_SCT   = 8;
  localparam int unsigned CPL_RDZ   = 12;
  localparam int unsigned CPL_VALID = 16;
  localparam int unsigned CPL_BUSY  = 17;
  localparam int unsigned LR_BIT    = 31;
  localparam int unsigned FUA_BIT   = 30;
  localparam int unsigned PRA_MSB   = 29;
  localparam int unsigned PRA_LSB   = 26;
  localparam int unsigned NLB_MSB   = 15;
  localparam int unsigned TAG_LSB   = 16;
  localparam int unsigned AF_MSB    = 3;
  localparam logic [3:0]  AF_MAX    = 4'h6;
  localparam int unsigned MAP_INV   = 0;
  localparam int unsigned MAP_ZERO  = 1;

  typedef enum logic [1:0] {BWV_IDLE, BWV_WALK, BWV_FLUSH, BWV_DONE} bwv_state_t;

endpackage

//--- rtl/bwv_blkmap.sv
`timescale 1ns/1ps
`default_nettype none
module bwv_blkmap
(
  // Clock and reset.
  input  wire logic                    mclk,
  input  wire logic                    srst,
  // Write port.
  input  wire logic                    we,
  input  wire logic [bwv_pkg::IDXW-1:0] waddr,
  input  wire logic [1:0]              wdata,
  // Read port.
  input  wire logic [bwv_pkg::IDXW-1:0] raddr,
  output logic [1:0]                   rdata
);
  import bwv_pkg::*;

  logic [1:0] mem [NBLK];

  // Reset clears every marker so no block starts invalid or known-zero.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NBLK; i++)
      begin
        mem[i] <= 2'h0;
      end
    end
    else if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read is combinational so the walker sees an entry in its own cycle.
  assign rdata = mem[raddr];

endmodule // bwv_blkmap
`default_nettype wire

//--- rtl/bwv_top.sv
// Behaviour
// - Every finished Write or Write Zeroes posts a completion with its status.
// - Write reports 80h conflict, 81h bad protection, 82h read-only range.
// - Write Zeroes reports command-specific 81h and 82h only, never 80h conflict; out of range gives generic 80h.
// - Reading a block marked invalid fails with Unrecovered Read Error.
// - A later write to a block clears its invalid mark.
// - First block address is dword 11 high half, dword 10 low half.
// - Write Uncorrectable dword 12 bits 15:0 hold zero-based block count.
// - After Write Zeroes, reads of its range return zeroes until rewritten.
// - Dword 12 bit 31 asks for limited retry effort.
// - Dword 12 bit 30 forces media commit before completion of Write and Write Zeroes.
// - Dword 12 bits 29:26 select protection action; 25:16 reserved.
// - Write Zeroes count is zero-based: value n covers n+1 blocks.
// - Dword 14 reference tag used only with protection formatting.
// - Dword 15 tag mask and value used only with protection formatting.
// - Finished Write Uncorrectable posts a completion with its status.
`timescale 1ns/1ps
`default_nettype none
module bwv_top
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        srst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Media back end.
  output logic             media_flush_req,
  input  wire logic        media_flush_ack,
  output logic             retry_limit,
  // Protection settings.
  output logic [3:0]       prot_action,
  output logic [31:0]      initial_reference_tag,
  output logic [15:0]      app_tag_mask,
  output logic [15:0]      app_tag_value,
  // Completion.
  output logic             cpl_post,
  output logic             cpl_valid,
  output logic             busy
);
  import bwv_pkg::*;

  typedef struct packed {
    bwv_state_t      st;
    logic            pi_fmt;
    logic            ro_en;
    logic [7:0]      opc;
    logic [15:0]     cid;
    logic [31:0]     dw10;
    logic [31:0]     dw11;
    logic [31:0]     dw12;
    logic [31:0]     dw13;
    logic [31:0]     dw14;
    logic [31:0]     dw15;
    logic [IDXW-1:0] ro_first;
    logic [IDXW-1:0] ro_last;
    logic [IDXW-1:0] cur;
    logic [15:0]     left;
    logic            bad;
    logic            nz;
    logic [2:0]      sct;
    logic [7:0]      sc;
    logic            rdz;
    logic            cvalid;
    logic [15:0]     ccid;
    logic            post;
    logic            flush;
  } bwv_regs_t;

  localparam bwv_regs_t RST = '0;

  // Zero-based block count of a command's dword 12.
  function automatic logic [15:0] nlb_of(input logic [31:0] dw);
    nlb_of = dw[NLB_MSB:0];
  endfunction

  bwv_regs_t       s_r;
  bwv_regs_t       s_nxt;
  logic [63:0]     first_block_address;
  logic [15:0]     block_count_minus_one;
  logic [16:0]     last_idx;
  logic            in_range;
  logic            ro_hit;
  logic            is_wr;
  logic            wr_acc;
  logic            go;
  logic            map_we;
  logic [1:0]      map_wd;
  logic [1:0]      map_rd;
  logic            limited_retry_flag;
  logic            force_media_commit;
  logic [3:0]      protection_action_field;

  assign first_block_address = {s_r.dw11, s_r.dw10};
  assign block_count_minus_one = nlb_of(s_r.dw12);
  assign limited_retry_flag = s_r.dw12[LR_BIT];
  assign force_media_commit = s_r.dw12[FUA_BIT];
  assign protection_action_field = s_r.dw12[PRA_MSB:PRA_LSB];

  // last block index covers n+1 blocks.
  assign last_idx = 17'(first_block_address[IDXW-1:0]) + 17'(block_count_minus_one);
  assign in_range = (first_block_address[63:IDXW] == '0) && (last_idx < 17'(NBLK));
  assign ro_hit   = s_r.ro_en && !((last_idx < 17'(s_r.ro_first))
                    || (first_block_address[IDXW-1:0] > s_r.ro_last));
  assign is_wr    = (s_r.opc == OPC_WR) || (s_r.opc == OPC_WZ);

  // The slave never waits, so every access completes in its access cycle.
  assign wr_acc = psel && penable && pwrite;
  assign go     = wr_acc && (paddr == A_CTRL) && pwdata[CTRL_GO] && (s_r.st == BWV_IDLE);

  bwv_blkmap u_map (
    .mclk  (mclk),
    .srst  (srst),
    .we    (map_we),
    .waddr (s_r.cur),
    .wdata (map_wd),
    .raddr (s_r.cur),
    .rdata (map_rd)
  );

  // Command fields are frozen while busy, so a write mid-command cannot corrupt it.
  always_comb
  begin
    s_nxt  = s_r;
    s_nxt.post = 1'b0;
    map_we = 1'b0;
    map_wd = 2'h0;
    if (wr_acc && (s_r.st == BWV_IDLE))
    begin
      if (paddr == A_CTRL)
      begin
        s_nxt.pi_fmt = pwdata[CTRL_PIF];
        s_nxt.ro_en  = pwdata[CTRL_ROEN];
      end
      else if (paddr == A_CMD)
      begin
        s_nxt.opc = pwdata[7:0];
        s_nxt.cid = pwdata[31:CMD_CID];
      end
      else if (paddr == A_DW10) s_nxt.dw10 = pwdata;
      else if (paddr == A_DW11) s_nxt.dw11 = pwdata;
      else if (paddr == A_DW12) s_nxt.dw12 = pwdata;
      else if (paddr == A_DW13) s_nxt.dw13 = pwdata;
      else if (paddr == A_DW14) s_nxt.dw14 = pwdata;
      else if (paddr == A_DW15) s_nxt.dw15 = pwdata;
      else if (paddr == A_ROFST) s_nxt.ro_first = pwdata[IDXW-1:0];
      else if (paddr == A_ROLST) s_nxt.ro_last = pwdata[IDXW-1:0];
    end
    // Software clears the completion flag; a post in the same cycle wins below.
    if (wr_acc && (paddr == A_CPL) && pwdata[CPL_VALID])
    begin
      s_nxt.cvalid = 1'b0;
    end
    case (s_r.st)
      BWV_IDLE:
      begin
        if (go)
        begin
          s_nxt.cur  = first_block_address[IDXW-1:0];
          s_nxt.left = block_count_minus_one;
          s_nxt.bad  = 1'b0;
          s_nxt.nz   = 1'b0;
          s_nxt.rdz  = 1'b0;
          s_nxt.sct  = SCT_GEN;
          s_nxt.sc   = SC_OK;
          s_nxt.st   = BWV_DONE;
          if (!is_wr && (s_r.opc != OPC_RD) && (s_r.opc != OPC_WU))
          begin
            s_nxt.sc = SC_BAD_OPC;
          end
          else if (!in_range)
          begin
            s_nxt.sc = SC_RANGE;
          end
          else if ((s_r.opc == OPC_WR) && (s_r.dw13[AF_MSB:0] > AF_MAX))
          begin
            s_nxt.sct = SCT_CS;
            s_nxt.sc  = SC_CONFLICT;
          end
          else if (is_wr && (protection_action_field != 4'h0) && !s_r.pi_fmt)
          begin
            s_nxt.sct = SCT_CS;
            s_nxt.sc  = SC_BAD_PI;
          end
          else if (is_wr && ro_hit)
          begin
            s_nxt.sct = SCT_CS;
            s_nxt.sc  = SC_RO;
          end
          else
          begin
            s_nxt.st = BWV_WALK;
          end
        end
      end
      BWV_WALK:
      begin
        if (s_r.opc == OPC_RD)
        begin
          s_nxt.bad = s_r.bad | map_rd[MAP_INV];
          s_nxt.nz  = s_r.nz | !map_rd[MAP_ZERO];
        end
        else
        begin
          map_we = 1'b1;
          if (s_r.opc == OPC_WU)
          begin
            map_wd = 2'(1 << MAP_INV);
          end
          else if (s_r.opc == OPC_WZ)
          begin
            map_wd = 2'(1 << MAP_ZERO);
          end
          else
          begin
            map_wd = 2'h0;
          end
        end
        if (s_r.left == 16'h0)
        begin
          if (s_r.opc == OPC_RD)
          begin
            s_nxt.rdz = !(s_r.nz | !map_rd[MAP_ZERO]);
            if (s_r.bad | map_rd[MAP_INV])
            begin
              s_nxt.sct = SCT_MEDIA;
              s_nxt.sc  = SC_URE;
            end
          end
          if (is_wr && force_media_commit)
          begin
            s_nxt.flush = 1'b1;
            s_nxt.st    = BWV_FLUSH;
          end
          else
          begin
            s_nxt.st = BWV_DONE;
          end
        end
        else
        begin
          s_nxt.left = s_r.left - 16'h1;
          s_nxt.cur  = s_r.cur + IDXW'(1);
        end
      end
      BWV_FLUSH:
      begin
        if (media_flush_ack)
        begin
          s_nxt.flush = 1'b0;
          s_nxt.st    = BWV_DONE;
        end
      end
      BWV_DONE:
      begin
        s_nxt.cvalid = 1'b1;
        s_nxt.ccid   = s_r.cid;
        s_nxt.post   = 1'b1;
        s_nxt.st     = BWV_IDLE;
      end
      default:
      begin
        s_nxt.st = BWV_IDLE;
      end
    endcase
  end

  // All control state sits in one registered struct.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_r <= RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Register read mux; unmapped addresses answer with an error and zero data.
  always_comb
  begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    if (paddr == A_CTRL) prdata = 32'({s_r.ro_en, s_r.pi_fmt, 1'b0});
    else if (paddr == A_CMD) prdata = {s_r.cid, 8'h0, s_r.opc};
    else if (paddr == A_DW10) prdata = s_r.dw10;
    else if (paddr == A_DW11) prdata = s_r.dw11;
    else if (paddr == A_DW12) prdata = s_r.dw12;
    else if (paddr == A_DW13) prdata = s_r.dw13;
    else if (paddr == A_DW14) prdata = s_r.dw14;
    else if (paddr == A_DW15) prdata = s_r.dw15;
    else if (paddr == A_ROFST) prdata = 32'(s_r.ro_first);
    else if (paddr == A_ROLST) prdata = 32'(s_r.ro_last);
    else if (paddr == A_CPL)
    begin
      prdata[7:0]                 = s_r.sc;
      prdata[CPL_SCT+2:CPL_SCT]   = s_r.sct;
      prdata[CPL_RDZ]             = s_r.rdz;
      prdata[CPL_VALID]           = s_r.cvalid;
      prdata[CPL_BUSY]            = (s_r.st != BWV_IDLE);
    end
    else if (paddr == A_CPLCID) prdata = 32'(s_r.ccid);
    else pslverr = psel && penable;
  end

  assign pready          = 1'b1;
  assign media_flush_req = s_r.flush;
  assign retry_limit     = (s_r.st != BWV_IDLE) && limited_retry_flag;
  assign prot_action           = s_r.pi_fmt ? protection_action_field : 4'h0;
  assign initial_reference_tag = s_r.pi_fmt ? s_r.dw14 : 32'h0;
  assign app_tag_mask          = s_r.pi_fmt ? s_r.dw15[31:TAG_LSB] : 16'h0;
  assign app_tag_value         = s_r.pi_fmt ? s_r.dw15[TAG_LSB-1:0] : 16'h0;
  assign cpl_post  = s_r.post;
  assign cpl_valid = s_r.cvalid;
  assign busy      = (s_r.st != BWV_IDLE);

  // Helper: cycles spent walking the current range.
  logic [16:0] walk_cnt_r;
  always_ff @(posedge mclk)
  begin
    if (srst || (s_r.st != BWV_WALK)) walk_cnt_r <= 17'h0;
    else walk_cnt_r <= walk_cnt_r + 17'h1;
  end

  property p_done_posts;
    @(posedge mclk) disable iff (srst) (s_r.st == BWV_DONE) |=> (cpl_post && cpl_valid);
  endproperty
  a_done_posts: assert property (p_done_posts)
    else $error("Completion not posted after done.");

  property p_ro_status;
    @(posedge mclk) disable iff (srst)
      (cpl_post && s_r.sct == SCT_CS && s_r.sc == SC_RO) |-> is_wr;
  endproperty
  a_ro_status: assert property (p_ro_status)
    else $error("Read-only status on a non-write command.");

  property p_wz_no_conflict;
    @(posedge mclk) disable iff (srst)
      (cpl_post && s_r.opc == OPC_WZ) |-> !(s_r.sct == SCT_CS && s_r.sc == SC_CONFLICT);
  endproperty
  a_wz_no_conflict: assert property (p_wz_no_conflict)
    else $error("Write Zeroes returned conflict status.");

  property p_read_invalid;
    @(posedge mclk) disable iff (srst)
      (s_r.st == BWV_WALK && s_r.opc == OPC_RD && map_rd[MAP_INV])
      |-> ##[1:300] (cpl_post && s_r.sct == SCT_MEDIA && s_r.sc == SC_URE);
  endproperty
  a_read_invalid: assert property (p_read_invalid)
    else $error("Invalid block read did not fail.");

  property p_write_clears;
    @(posedge mclk) disable iff (srst)
      (map_we && s_r.opc != OPC_WU) |=> !$past(map_wd[MAP_INV]);
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("Write left a block marked invalid.");

  property p_walk_len;
    @(posedge mclk) disable iff (srst)
      (s_r.st == BWV_WALK && s_nxt.st != BWV_WALK)
      |-> (walk_cnt_r == 17'(nlb_of(s_r.dw12)));
  endproperty
  a_walk_len: assert property (p_walk_len)
    else $error("Walk length differs from block count plus one.");

  property p_flush_hold;
    @(posedge mclk) disable iff (srst)
      (media_flush_req && !media_flush_ack) |=> (media_flush_req && !cpl_post);
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("Completion before media commit.");

  property p_tags_gated;
    @(posedge mclk) disable iff (srst)
      !s_r.pi_fmt |-> (initial_reference_tag == 32'h0 && app_tag_mask == 16'h0
                       && app_tag_value == 16'h0 && prot_action == 4'h0);
  endproperty
  a_tags_gated: assert property (p_tags_gated)
    else $error("Tags driven without protection formatting.");

  property p_retry;
    @(posedge mclk) disable iff (srst)
      (busy && s_r.dw12[LR_BIT]) |-> retry_limit;
  endproperty
  a_retry: assert property (p_retry)
    else $error("Limited retry not signalled.");

endmodule // bwv_top
`default_nettype wire

//--- verif/bwv_media_model.sv
`timescale 1ns/1ps
`default_nettype none
module bwv_media_model
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       srst,
  // Flush handshake.
  input  wire logic       media_flush_req,
  input  wire logic [3:0] ack_delay,
  output logic            media_flush_ack
);
  logic [3:0] cnt_r;

  // Ack rises ack_delay+1 cycles after the request; the counter saturates so one request gets one ack.
  // commit before ack
  always_ff @(posedge mclk)
  begin
    if (srst || !media_flush_req)
    begin
      cnt_r           <= 4'h0;
      media_flush_ack <= 1'b0;
    end
    else
    begin
      media_flush_ack <= (cnt_r == ack_delay);
      if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // bwv_media_model
`default_nettype wire

//--- verif/bwv_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bwv_top_tb;
  import bwv_pkg::*;
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr, pif, roen, fseen;
  logic        media_flush_req, media_flush_ack, retry_limit, cpl_post, cpl_valid, busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, itag, rv;
  logic [3:0]  prot_action, ack_delay;
  logic [15:0] tmask, tval;
  logic [5:0]  ro_a, ro_b;
  logic [1:0]  mk [NBLK];
  logic [7:0]  ops [5] = '{OPC_WR, OPC_RD, OPC_WU, OPC_WZ, 8'h10};
  int          num_errors, n_tests, cyc;

  bwv_top u_bwv_top (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .media_flush_req(media_flush_req), .media_flush_ack(media_flush_ack),
    .retry_limit(retry_limit), .prot_action(prot_action), .initial_reference_tag(itag),
    .app_tag_mask(tmask), .app_tag_value(tval), .cpl_post(cpl_post),
    .cpl_valid(cpl_valid), .busy(busy));
  bwv_media_model u_bwv_media_model (.mclk(mclk), .srst(srst),
    .media_flush_req(media_flush_req), .ack_delay(ack_delay),
    .media_flush_ack(media_flush_ack));

  // Free-running clock; a hang is cut off by the cycle ceiling.
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (fseen === 1'b0 && media_flush_req === 1'b1) fseen <= 1'b1;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer, then one idle cycle so no strobe is driven twice in a step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait for the answer.
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // Expected completion word from the bench's own block map; applies success effects.
  function automatic logic [31:0] exp_cpl(input logic [7:0] op, input logic [63:0] lba,
                                          input logic [31:0] d12, input logic [31:0] d13);
    logic [2:0] t;
    logic [7:0] c;
    logic       inv, zer, ro, rdz, wt;
    int         f, l;
    t = SCT_GEN;
    c = SC_OK;
    {inv, zer, ro, rdz} = 4'b0100;
    wt = (op == OPC_WR || op == OPC_WZ);
    f = int'(lba[5:0]);
    l = f + int'(d12[15:0]);
    if (op != OPC_WR && op != OPC_RD && op != OPC_WU && op != OPC_WZ) c = SC_BAD_OPC;
    else if (lba > 64'd63 || lba + d12[15:0] > 64'd63) c = SC_RANGE;
    else
    begin
      for (int b = f; b <= l; b++)
      begin
        inv |= mk[b][MAP_INV];
        zer &= mk[b][MAP_ZERO];
        ro  |= roen && b >= ro_a && b <= ro_b;
      end
      if (op == OPC_WR && d13[3:0] > AF_MAX) {t, c} = {SCT_CS, SC_CONFLICT};
      else if (wt && d12[29:26] != 4'h0 && !pif) {t, c} = {SCT_CS, SC_BAD_PI};
      else if (wt && ro) {t, c} = {SCT_CS, SC_RO};
      else if (op == OPC_RD && inv) {t, c} = {SCT_MEDIA, SC_URE};
      else if (op == OPC_RD) rdz = zer;
      else
        for (int b = f; b <= l; b++)
          mk[b] = (op == OPC_WZ) ? 2'b10 : (op == OPC_WU) ? 2'b01 : 2'b00;
    end
    return {15'h0, 1'b1, 3'h0, rdz, 1'b0, t, c};
  endfunction

  // Load one command as host software would, start it and judge its completion.
  task automatic cmd(input logic [7:0] op, input logic [63:0] lba, input logic [31:0] d12,
                     input logic [31:0] d13, input logic [3:0] dly, input logic poke);
    logic [31:0] r, e, t14, t15;
    logic [15:0] cid;
    logic        er, wu;
    int          n;
    wu  = (op == OPC_WU);
    cid = 16'($urandom);
    d12 = wu ? {16'h0, d12[15:0]} : d12 & 32'hfc00ffff;
    d13 = (op == OPC_WR) ? d13 : 32'h0;
    t14 = wu ? 32'h0 : $urandom;
    t15 = wu ? 32'h0 : $urandom;
    e   = exp_cpl(op, lba, d12, d13);
    ack_delay <= dly;
    fseen     <= 1'b0;
    wr(A_CMD, {cid, 8'h00, op});
    wr(A_DW10, lba[31:0]);
    wr(A_DW11, lba[63:32]);
    wr(A_DW12, d12);
    wr(A_DW13, d13);
    wr(A_DW14, t14);
    wr(A_DW15, t15);
    wr(A_ROFST, {26'h0, ro_a});
    wr(A_ROLST, {26'h0, ro_b});
    wr(A_CTRL, {29'h0, roen, pif, 1'b0});
    chk("prot_action", prot_action, pif ? d12[29:26] : 4'h0);
    chk("ref_tag", itag, pif ? t14 : 32'h0);
    chk("tag_mask_value", {tmask, tval}, pif ? t15 : 32'h0);
    wr(A_CTRL, {29'h0, roen, pif, 1'b1});
    // n counts edges since the go edge; the two poke writes add six of them.
    n = 1;
    if (poke)
    begin
      wr(A_CMD, {~cid, 8'h00, OPC_WU});
      wr(A_CTRL, 32'h1);
      n = 7;
    end
    // Look after the edge has settled, so a decode-error pulse is not missed.
    #1;
    while (cpl_post !== 1'b1)
    begin
      @(posedge mclk);
      #1;
      n++;
      if (busy === 1'b1) chk("retry_limit", retry_limit, d12[31]);
    end
    @(posedge mclk);
    if (e[7:0] != SC_OK && e[10:8] != SCT_MEDIA) chk("err_latency", n, 1);
    else if (!wu && op != OPC_RD && d12[30])
    begin
      chk("flush", fseen, 1'b1);
      chk("flush_wait", n, d12[15:0] + 4 + dly);
    end
    else
    begin
      chk("flush", fseen, 1'b0);
      chk("walk_latency", n, d12[15:0] + 2);
    end
    apb(1'b0, A_CPL, 32'h0, r, er);
    chk("cpl", r & 32'h0003_17ff, e);
    apb(1'b0, A_CPLCID, 32'h0, r, er);
    chk("cpl_cid", r[15:0], cid);
    wr(A_CPL, 32'h0001_0000);
    chk("cpl_valid", cpl_valid, 1'b0);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    foreach (mk[i]) mk[i] = 2'b00;
    @(posedge mclk);
    chk("idle", {pready, busy, cpl_valid, media_flush_req}, 4'h8);
  endtask

  // Fixed corners first, then seeded random commands, then a second reset.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, srst} = '0;
    {pif, roen, fseen, ack_delay, num_errors, n_tests, cyc} = '0;
    {ro_a, ro_b} = {6'd40, 6'd41};
    rv = $urandom(32'h8bd6b91b);
    do_reset();
    apb(1'b0, 8'h40, 32'h0, rv, pif);
    chk("unmapped_err", 32'(pif), 32'h1);
    chk("unmapped_data", rv, 32'h0);
    pif  = 1'b0;
    roen = 1'b1;
    cmd(OPC_WU, 64'd10, 32'h8000_0002, 0, 0, 0);
    cmd(OPC_RD, 64'd11, 32'h0, 0, 0, 0);
    cmd(OPC_WR, 64'd11, 32'h0, 0, 0, 0);
    cmd(OPC_RD, 64'd11, 32'h0, 0, 0, 0);
    cmd(OPC_RD, 64'd10, 32'h2, 0, 0, 0);
    cmd(OPC_WZ, 64'd20, 32'h4000_0003, 0, 5, 0);
    cmd(OPC_RD, 64'd20, 32'h3, 0, 0, 0);
    cmd(OPC_RD, 64'd20, 32'h4, 0, 0, 0);
    cmd(OPC_WR, 64'd30, 32'h0, 32'h7, 0, 0);
    cmd(OPC_WR, 64'd30, 32'h0, 32'h6, 0, 0);
    cmd(OPC_WZ, 64'd30, 32'h0400_0000, 0, 0, 0);
    cmd(OPC_WZ, 64'd39, 32'h1, 0, 0, 0);
    cmd(OPC_WR, 64'd41, 32'h0, 0, 0, 0);
    cmd(OPC_WZ, 64'h1_0000_0000, 32'h0, 0, 0, 0);
    cmd(OPC_WZ, 64'd63, 32'h0, 0, 0, 0);
    cmd(OPC_WZ, 64'd63, 32'h1, 0, 0, 0);
    cmd(8'h10, 64'd0, 32'h0, 0, 0, 0);
    cmd(OPC_WZ, 64'd0, 32'h8000_0014, 0, 0, 1);
    pif = 1'b1;
    cmd(OPC_WZ, 64'd50, 32'h0c00_0001, 0, 0, 0);
    repeat (40)
    begin
      pif  = 1'($urandom);
      roen = 1'($urandom);
      ro_a = 6'($urandom_range(0, 60));
      ro_b = ro_a + 6'($urandom_range(0, 3));
      cmd(ops[$urandom_range(0, 4)], 64'($urandom_range(0, 68)),
          {16'($urandom_range(0, 16'hffff)), 16'($urandom_range(0, 6))},
          32'($urandom_range(0, 8)), 4'($urandom_range(0, 6)), 1'b0);
    end
    do_reset();
    cmd(OPC_RD, 64'd0, 32'h3f, 0, 0, 0);
    finish_test();
  end
endmodule // bwv_top_tb
`default_nettype wire
